// ===== bench/eha_assertions.sv
`timescale 1ns/1ns
module eha_checker (
  input wire logic                       ref_clk,
  input wire logic                       srst,
  input wire logic                       ev_ready,
  input wire logic                       mem_wr_valid,
  input eha_pkg::eha_mem_wr_t            mem_wr,
  input wire logic                       mem_wr_ready,
  input wire logic                       proc_rd_en,
  input wire logic [eha_pkg::MEM_AW-1:0] proc_rd_addr,
  input wire logic                       mem_rd_en,
  input wire logic [eha_pkg::MEM_AW-1:0] mem_rd_addr,
  input wire logic                       mem_rd_valid,
  input wire logic [eha_pkg::MEM_DW-1:0] mem_rd_data,
  input wire logic                       proc_rd_valid,
  input wire logic [eha_pkg::MEM_DW-1:0] proc_rd_data,
  input wire logic                       bg_rd_en,
  input wire logic                       bg_rd_valid,
  input wire logic                       snap_done
);
  // ==========
  // Position of the next word inside the snapshot being written
  logic [11:0]                wr_idx;
  logic [11:0]                next_wr_idx;
  logic [eha_pkg::MEM_AW-1:0] last_addr;
  logic [eha_pkg::MEM_AW-1:0] next_last_addr;
  logic                       acc;
  assign acc = mem_wr_valid && mem_wr_ready;
  always_comb begin
    next_wr_idx    = wr_idx;
    next_last_addr = last_addr;
    if (srst) begin
      next_wr_idx    = 12'h000;
      next_last_addr = '0;
    end else if (acc) begin
      next_last_addr = mem_wr.addr;
      next_wr_idx    = (wr_idx == 12'h800) ? 12'h000 : wr_idx + 12'h001;
    end
  end
  always_ff @(posedge ref_clk) begin
    wr_idx    <= next_wr_idx;
    last_addr <= next_last_addr;
  end

  // ==========
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_wr_seq;
    acc && wr_idx != 12'h000 |-> mem_wr.addr == last_addr + 25'h0000001;
  endproperty
  a_wr_seq: assert property (p_wr_seq)
    else $error("snapshot word address not consecutive");
  property p_wr_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("stalled snapshot word changed");
  property p_done_gap;
    snap_done |=> !snap_done [*8];
  endproperty
  a_done_gap: assert property (p_done_gap)
    else $error("snapshot done not a lone pulse");
  property p_ready_stays;
    ev_ready |=> ev_ready;
  endproperty
  a_ready_stays: assert property (p_ready_stays)
    else $error("event stream back-pressured");
  property p_rd_fwd;
    proc_rd_en |=> mem_rd_en && mem_rd_addr == $past(proc_rd_addr);
  endproperty
  a_rd_fwd: assert property (p_rd_fwd)
    else $error("processor read not forwarded");
  property p_rd_quiet;
    !proc_rd_en |=> !mem_rd_en;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("spurious memory read");
  property p_rd_ret;
    mem_rd_valid |=> proc_rd_valid && proc_rd_data == $past(mem_rd_data);
  endproperty
  a_rd_ret: assert property (p_rd_ret)
    else $error("read data not returned");
  property p_bg_rd;
    bg_rd_en |=> bg_rd_valid;
  endproperty
  a_bg_rd: assert property (p_bg_rd)
    else $error("background read not answered");
  property p_bg_quiet;
    !bg_rd_en |=> !bg_rd_valid;
  endproperty
  a_bg_quiet: assert property (p_bg_quiet)
    else $error("spurious background answer");
endmodule : eha_checker

bind eha_histogram_accumulator eha_checker u_eha_checker (
  .ref_clk(ref_clk), .srst(srst), .ev_ready(ev_ready), .mem_wr_valid(mem_wr_valid),
  .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready), .proc_rd_en(proc_rd_en),
  .proc_rd_addr(proc_rd_addr), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
  .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .proc_rd_valid(proc_rd_valid),
  .proc_rd_data(proc_rd_data), .bg_rd_en(bg_rd_en), .bg_rd_valid(bg_rd_valid),
  .snap_done(snap_done)
);

// ===== bench/eha_fe_model.sv
`timescale 1ns/1ns
module eha_fe_model (
  input  wire logic           ref_clk,
  input  wire logic           ev_ready,
  output logic                ev_valid,
  output eha_pkg::eha_event_t ev_word,
  output logic                fe_live
);
  initial begin
    ev_valid = 1'b0;
    ev_word  = '0;
    fe_live  = 1'b0;
  end

  // ==========
  // Event words, back to back or spaced by gap idle cycles
  task automatic send(input logic [11:0] amp, input logic [5:0] det, input int n, input int gap);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      @(negedge ref_clk);
      ev_valid    = 1'b1;
      ev_word.amp = amp;
      ev_word.det = det;
      for (k = 0; k < 8 && ev_ready !== 1'b1; k++) @(negedge ref_clk);
      if (gap > 0) begin
        @(negedge ref_clk);
        ev_valid = 1'b0;
        ev_word  = ~ev_word;
        repeat (gap - 1) @(negedge ref_clk);
      end
    end
    @(negedge ref_clk);
    ev_valid = 1'b0;
    ev_word  = ~ev_word;
  endtask : send

  // Front end able to accept events for n clock edges
  task automatic live(input int n);
    @(negedge ref_clk);
    fe_live = 1'b1;
    repeat (n) @(negedge ref_clk);
    fe_live = 1'b0;
  endtask : live
endmodule : eha_fe_model

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                 ref_clk, srst, ev_valid, ev_ready, fe_live, lut_wr_en, bg_enable;
  logic                 bg_rd_en, bg_rd_valid, mem_wr_valid, mem_wr_ready, proc_rd_en;
  logic                 mem_rd_en, mem_rd_valid, proc_rd_valid, snap_done, snap_overrun, edac_err;
  eha_pkg::eha_event_t  ev_word;
  eha_pkg::eha_mem_wr_t mem_wr;
  logic [11:0]          lut_wr_addr, bg_rd_addr;
  logic [4:0]           lut_wr_bin;
  logic [5:0]           bg_det;
  logic [15:0]          bg_rd_data;
  logic [24:0]          proc_rd_addr, mem_rd_addr, snap_base;
  logic [31:0]          mem_rd_data, proc_rd_data;
  int                   fail_count, n_compared, i;
  int                   wr_cnt = 0;
  int                   n_snap = 0;
  int                   cyc = 0;
  int                   n_flag = 0;
  logic [24:0]          start_addr [2];
  logic [31:0]          snap [2][2049];
  logic [31:0]          exp_w [2049];

  eha_histogram_accumulator #(.SNAP_CYCLES(12000)) u_eha_histogram_accumulator (
    .ref_clk(ref_clk), .srst(srst), .ev_valid(ev_valid), .ev_word(ev_word),
    .ev_ready(ev_ready), .fe_live(fe_live), .lut_wr_en(lut_wr_en), .lut_wr_addr(lut_wr_addr),
    .lut_wr_bin(lut_wr_bin), .bg_enable(bg_enable), .bg_det(bg_det), .bg_rd_en(bg_rd_en),
    .bg_rd_addr(bg_rd_addr), .bg_rd_data(bg_rd_data), .bg_rd_valid(bg_rd_valid),
    .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
    .proc_rd_en(proc_rd_en), .proc_rd_addr(proc_rd_addr), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .proc_rd_valid(proc_rd_valid), .proc_rd_data(proc_rd_data), .snap_base(snap_base),
    .snap_done(snap_done), .snap_overrun(snap_overrun), .edac_err(edac_err)
  );
  eha_fe_model u_eha_fe_model (
    .ref_clk(ref_clk), .ev_ready(ev_ready), .ev_valid(ev_valid), .ev_word(ev_word),
    .fe_live(fe_live)
  );

  // ==========
  // Storage memory: stalls one write in three, reads answer next cycle
  always @(negedge ref_clk) begin
    cyc          <= cyc + 1;
    mem_wr_ready <= (cyc % 3) != 0;
    mem_rd_valid <= mem_rd_en;
    mem_rd_data  <= mem_rd_en ? {7'h00, mem_rd_addr} ^ 32'hA5A5_0000 : ~mem_rd_data;
  end
  always @(posedge ref_clk) begin
    if (mem_wr_valid && mem_wr_ready && n_snap < 2) begin
      if (wr_cnt == 0) start_addr[n_snap] <= mem_wr.addr;
      snap[n_snap][wr_cnt] <= mem_wr.data;
      wr_cnt <= (wr_cnt == 2048) ? 0 : wr_cnt + 1;
      if (wr_cnt == 2048) n_snap <= n_snap + 1;
    end
    if (snap_overrun || edac_err) n_flag <= n_flag + 1;
  end

  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic lut_write(input logic [11:0] a, input logic [4:0] b);
    @(negedge ref_clk);
    lut_wr_en   = 1'b1;
    lut_wr_addr = a;
    lut_wr_bin  = b;
    @(negedge ref_clk);
    lut_wr_en = 1'b0;
  endtask : lut_write

  task automatic bg_read(input logic [11:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    bg_rd_en   = 1'b1;
    bg_rd_addr = a;
    @(negedge ref_clk);
    bg_rd_en   = 1'b0;
    bg_rd_addr = ~a;
    chk(bg_rd_valid, 32'h1, "background valid");
    chk(bg_rd_data, e, "background count");
  endtask : bg_read

  task automatic proc_read(input logic [24:0] a);
    int k;
    @(negedge ref_clk);
    proc_rd_en   = 1'b1;
    proc_rd_addr = a;
    @(negedge ref_clk);
    proc_rd_en   = 1'b0;
    proc_rd_addr = ~a;
    chk(mem_rd_addr, a, "memory read address");
    for (k = 0; k < 8 && proc_rd_valid !== 1'b1; k++) @(negedge ref_clk);
    chk(proc_rd_data, {7'h00, a} ^ 32'hA5A5_0000, "processor read data");
  endtask : proc_read

  task automatic wait_snap(input int k);
    int j;
    for (j = 0; j < 30000 && n_snap < k; j++) @(negedge ref_clk);
    if (n_snap < k) begin
      fail_count++;
      $display("BAD %0t snapshot never completed", $time);
      wrap_up();
    end
  endtask : wait_snap

  task automatic check_snap(input int k);
    for (int j = 0; j < 2048; j++) chk(snap[k][j], exp_w[j], "counter word");
    chk(snap[k][2048], exp_w[2048], "live time word");
  endtask : check_snap

  // ==========
  // Scenarios
  task automatic t_first_interval();
    lut_write(12'h005, 5'h04);
    lut_write(12'h123, 5'h02);
    lut_write(12'h123, 5'h1F);
    lut_write(12'hFFF, 5'h1F);
    lut_write(12'h080, 5'h01);
    @(negedge ref_clk);
    bg_enable = 1'b1;
    bg_det    = 6'h07;
    u_eha_fe_model.send(12'h005, 6'h07, 3, 0);
    u_eha_fe_model.send(12'h123, 6'h3F, 2, 2);
    u_eha_fe_model.send(12'hFFF, 6'h00, 1, 0);
    u_eha_fe_model.live(100);
    bg_read(12'h005, 16'h0003);
    bg_read(12'h005, 16'h0000);
    bg_read(12'hFFF, 16'h0000);
    exp_w = '{default: 32'h0};
    exp_w[263]  = 32'h3;
    exp_w[2047] = 32'h2;
    exp_w[1984] = 32'h1;
    exp_w[2048] = 32'h64;
    for (i = 0; i < 15000 && snap_done !== 1'b1; i++) @(negedge ref_clk);
    chk(snap_done, 32'h1, "snapshot done");
    chk(snap_base, start_addr[0], "snapshot base");
    proc_read(25'h1ABCDE);
    wait_snap(1);
    check_snap(0);
  endtask : t_first_interval

  task automatic t_second_interval();
    exp_w = '{default: 32'h0};
    exp_w[65]   = 32'h4;
    exp_w[2048] = 32'h32;
    u_eha_fe_model.send(12'h080, 6'h01, 4, 0);
    u_eha_fe_model.live(50);
    wait_snap(2);
    check_snap(1);
    chk(start_addr[1], start_addr[0] + 25'h0000801, "next snapshot start");
    chk(n_flag, 32'h0, "overrun or parity pulses");
  endtask : t_second_interval

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    srst         = 1'b1;
    lut_wr_en    = 1'b0;
    lut_wr_addr  = '0;
    lut_wr_bin   = '0;
    bg_enable    = 1'b0;
    bg_det       = '0;
    bg_rd_en     = 1'b0;
    bg_rd_addr   = '0;
    proc_rd_en   = 1'b0;
    proc_rd_addr = '0;
    fail_count   = 0;
    n_compared   = 0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    for (i = 0; i < 5000 && ev_ready !== 1'b1; i++) @(negedge ref_clk);
    chk(ev_ready, 32'h1, "ready after init");
    t_first_interval();
    t_second_interval();
    wrap_up();
  end
endmodule : tb_top

// ===== hw/eha_fifo.sv
`timescale 1ns/1ns
module eha_fifo #(
  parameter int WIDTH = 57,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("eha_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // ==========
  // Pointers and flags
  always_comb begin
    in_ready    = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    out_valid   = (wr_ptr != rd_ptr);
    out_data    = mem[rd_ptr[AW-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule : eha_fifo

// ===== hw/eha_histogram_accumulator.sv
`timescale 1ns/1ns
// Behaviour
// [RULE1] Front end sends 12-bit amplitude, 6-bit detector
// [RULE2] Programmable table maps amplitude to 32 bins
// [RULE3] 2048 counters, one per bin and detector
// [RULE4] Ten snapshots per second, with live time
// [RULE5] 128 MByte circular store, newest overwrites oldest
// [RULE6] Accumulation and dumping need no processor action
// [RULE7] Processor reads store without stalling accumulation
// [RULE8] Full-resolution background spectra over long intervals
// [RULE9] Parity check on counters in same logic
// [RULE10] Counters and live time restart at capture
// [RULE11] Live time counts cycles front end accepts
module eha_histogram_accumulator #(
  parameter int CNT_W       = 16,
  parameter int BG_W        = 16,
  parameter int SNAP_CYCLES = eha_pkg::SNAP_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        ev_valid,
  input  eha_pkg::eha_event_t              ev_word,
  output logic                             ev_ready,
  input  wire logic                        fe_live,
  input  wire logic                        lut_wr_en,
  input  wire logic [eha_pkg::AMP_W-1:0]   lut_wr_addr,
  input  wire logic [eha_pkg::BIN_W-1:0]   lut_wr_bin,
  input  wire logic                        bg_enable,
  input  wire logic [eha_pkg::DET_W-1:0]   bg_det,
  input  wire logic                        bg_rd_en,
  input  wire logic [eha_pkg::AMP_W-1:0]   bg_rd_addr,
  output logic      [BG_W-1:0]             bg_rd_data,
  output logic                             bg_rd_valid,
  output logic                             mem_wr_valid,
  output eha_pkg::eha_mem_wr_t             mem_wr,
  input  wire logic                        mem_wr_ready,
  input  wire logic                        proc_rd_en,
  input  wire logic [eha_pkg::MEM_AW-1:0]  proc_rd_addr,
  output logic                             mem_rd_en,
  output logic      [eha_pkg::MEM_AW-1:0]  mem_rd_addr,
  input  wire logic                        mem_rd_valid,
  input  wire logic [eha_pkg::MEM_DW-1:0]  mem_rd_data,
  output logic                             proc_rd_valid,
  output logic      [eha_pkg::MEM_DW-1:0]  proc_rd_data,
  output logic      [eha_pkg::MEM_AW-1:0]  snap_base,
  output logic                             snap_done,
  output logic                             snap_overrun,
  output logic                             edac_err
);

  localparam int IW = eha_pkg::ACC_IDX_W;
  localparam int AW = eha_pkg::AMP_W;
  localparam int FW = $bits(eha_pkg::eha_mem_wr_t);

  if (CNT_W < 2 || CNT_W > eha_pkg::MEM_DW || BG_W < 2 || SNAP_CYCLES < 4 * eha_pkg::SNAP_WORDS
      || eha_pkg::MEM_BYTES != eha_pkg::WORD_BYTES * (1 << eha_pkg::MEM_AW)) begin : g_bad_cfg
    $error("eha_histogram_accumulator parameters out of range");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [CNT_W:0] eha_protect(input logic [CNT_W-1:0] cnt);
    eha_protect = {^cnt, cnt};
  endfunction : eha_protect

  function automatic logic [CNT_W-1:0] eha_sat_inc(input logic [CNT_W-1:0] cnt);
    eha_sat_inc = (&cnt) ? cnt : cnt + 1'b1;
  endfunction : eha_sat_inc

  // ==========================================================================
  // Storage
  logic [eha_pkg::BIN_W-1:0] lut [eha_pkg::N_AMP];
  logic [CNT_W:0]            acc [2][eha_pkg::N_ACC];
  logic [BG_W-1:0]           bg  [eha_pkg::N_AMP];

  // ==========================================================================
  // State
  eha_pkg::eha_state_t         state,        next_state;
  logic                        active,       next_active;
  logic [AW-1:0]               idx,          next_idx;
  logic [31:0]                 tick_cnt,     next_tick_cnt;
  logic [31:0]                 live_cnt,     next_live_cnt;
  logic [31:0]                 live_hold,    next_live_hold;
  logic [eha_pkg::MEM_AW-1:0]  wr_ptr,       next_wr_ptr;
  logic [eha_pkg::MEM_AW-1:0]  snap_start,   next_snap_start;
  logic                        s1_valid,     next_s1_valid;
  logic                        s1_bg,        next_s1_bg;
  logic [IW-1:0]               s1_idx,       next_s1_idx;
  logic [AW-1:0]               s1_amp,       next_s1_amp;
  logic                        next_ev_ready;
  logic [eha_pkg::MEM_AW-1:0]  next_snap_base;
  logic                        next_snap_done;
  logic                        next_snap_overrun;
  logic                        next_edac_err;
  logic [BG_W-1:0]             next_bg_rd_data;
  logic                        next_bg_rd_valid;
  logic                        next_mem_wr_valid;
  eha_pkg::eha_mem_wr_t        next_mem_wr;
  logic                        next_mem_rd_en;
  logic [eha_pkg::MEM_AW-1:0]  next_mem_rd_addr;
  logic                        next_proc_rd_valid;
  logic [eha_pkg::MEM_DW-1:0]  next_proc_rd_data;

  logic                        tick;
  logic                        acc_we   [2];
  logic [IW-1:0]               acc_wa   [2];
  logic [CNT_W:0]              acc_wd   [2];
  logic [CNT_W:0]              old_word;
  logic [CNT_W:0]              cur_word;
  logic                        bg_clr_we;
  logic [AW-1:0]               bg_clr_a;
  logic                        bg_inc_we;
  logic [BG_W-1:0]             bg_inc_d;
  logic                        fifo_in_valid;
  logic                        fifo_in_ready;
  eha_pkg::eha_mem_wr_t        fifo_in;
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  logic [FW-1:0]               fifo_out;

  // ==========================================================================
  // Event pipeline: table lookup, then increment
  always_comb begin
    next_s1_valid = ev_valid && ev_ready;
    next_s1_idx   = {lut[ev_word.amp], ev_word.det};                         // [RULE1] [RULE2]
    next_s1_amp   = ev_word.amp;
    next_s1_bg    = bg_enable && (ev_word.det == bg_det);                    // [RULE8]
    next_ev_ready = (next_state != eha_pkg::EHA_ST_INIT);
  end

  always_ff @(posedge ref_clk) begin
    if (lut_wr_en) begin
      lut[lut_wr_addr] <= lut_wr_bin;                                        // [RULE2]
    end
  end

  // ==========================================================================
  // Snapshot sequencer
  always_comb begin
    tick              = (tick_cnt == 32'(SNAP_CYCLES - 1));
    next_tick_cnt     = tick ? '0 : tick_cnt + 1'b1;                         // [RULE6]
    next_live_cnt     = (fe_live && !(&live_cnt)) ? live_cnt + 1'b1 : live_cnt; // [RULE11]
    next_live_hold    = live_hold;
    next_state        = state;
    next_active       = active;
    next_idx          = idx;
    next_wr_ptr       = wr_ptr;
    next_snap_start   = snap_start;
    next_snap_base    = snap_base;
    next_snap_done    = 1'b0;
    next_snap_overrun = tick && (state == eha_pkg::EHA_ST_DUMP || state == eha_pkg::EHA_ST_LIVE);
    next_edac_err     = 1'b0;
    old_word          = acc[~active][idx[IW-1:0]];
    fifo_in_valid     = 1'b0;
    fifo_in.addr      = wr_ptr;
    fifo_in.data      = '0;
    if (tick && state == eha_pkg::EHA_ST_IDLE) begin
      next_active     = ~active;                                             // [RULE10]
      next_live_hold  = live_cnt;                                            // [RULE4]
      next_live_cnt   = fe_live ? 32'h0000_0001 : '0;                        // [RULE10]
      next_snap_start = wr_ptr;
      next_idx        = '0;
      next_state      = eha_pkg::EHA_ST_DUMP;
    end
    case (state)
      eha_pkg::EHA_ST_INIT: begin
        next_idx = idx + 1'b1;
        if (&idx) begin
          next_state = eha_pkg::EHA_ST_IDLE;
        end
      end
      eha_pkg::EHA_ST_IDLE: begin
      end
      eha_pkg::EHA_ST_DUMP: begin
        fifo_in_valid = 1'b1;
        fifo_in.data  = eha_pkg::MEM_DW'(old_word[CNT_W-1:0]);               // [RULE4]
        if (fifo_in_ready) begin
          next_edac_err = (^old_word);                                       // [RULE9]
          next_wr_ptr   = wr_ptr + 1'b1;                                     // [RULE5]
          next_idx      = idx + 1'b1;
          if (idx[IW-1:0] == IW'(eha_pkg::N_ACC - 1)) begin
            next_state = eha_pkg::EHA_ST_LIVE;
          end
        end
      end
      eha_pkg::EHA_ST_LIVE: begin
        fifo_in_valid = 1'b1;
        fifo_in.data  = live_hold;                                           // [RULE4] [RULE11]
        if (fifo_in_ready) begin
          next_wr_ptr    = wr_ptr + 1'b1;                                    // [RULE5]
          next_snap_base = snap_start;
          next_snap_done = 1'b1;
          next_state     = eha_pkg::EHA_ST_IDLE;
        end
      end
      default: begin
        next_state = eha_pkg::EHA_ST_INIT;
      end
    endcase
  end

  // ==========================================================================
  // Counter banks: live bank counts, other bank drains and clears
  always_comb begin
    cur_word = acc[active][s1_idx];
    for (int b = 0; b < 2; b++) begin
      acc_we[b] = 1'b0;
      acc_wa[b] = s1_idx;
      acc_wd[b] = eha_protect(eha_sat_inc(cur_word[CNT_W-1:0]));             // [RULE3] [RULE9]
      if (state == eha_pkg::EHA_ST_INIT) begin
        acc_we[b] = 1'b1;
        acc_wa[b] = idx[IW-1:0];
        acc_wd[b] = '0;
      end else if (s1_valid && active == 1'(b)) begin
        acc_we[b] = 1'b1;                                                    // [RULE3]
      end else if (state == eha_pkg::EHA_ST_DUMP && fifo_in_ready && active != 1'(b)) begin
        acc_we[b] = 1'b1;                                                    // [RULE10]
        acc_wa[b] = idx[IW-1:0];
        acc_wd[b] = '0;
      end
    end
  end

  for (genvar gb = 0; gb < 2; gb++) begin : g_bank
    always_ff @(posedge ref_clk) begin
      if (acc_we[gb]) begin
        acc[gb][acc_wa[gb]] <= acc_wd[gb];
      end
    end
  end

  // ==========================================================================
  // Background spectrum: read clears, a coinciding event survives
  always_comb begin
    bg_clr_we        = bg_rd_en || (state == eha_pkg::EHA_ST_INIT);
    bg_clr_a         = (state == eha_pkg::EHA_ST_INIT) ? idx : bg_rd_addr;
    bg_inc_we        = s1_valid && s1_bg;                                    // [RULE8]
    bg_inc_d         = (bg_clr_we && bg_clr_a == s1_amp) ? BG_W'(1)
                       : ((&bg[s1_amp]) ? bg[s1_amp] : bg[s1_amp] + 1'b1);
    next_bg_rd_valid = bg_rd_en;
    next_bg_rd_data  = bg_rd_en ? bg[bg_rd_addr] : bg_rd_data;
  end

  always_ff @(posedge ref_clk) begin
    if (bg_clr_we) begin
      bg[bg_clr_a] <= '0;
    end
    if (bg_inc_we) begin
      bg[s1_amp] <= bg_inc_d;                                                // [RULE8]
    end
  end

  // ==========================================================================
  // Store write path and processor read path
  eha_fifo #(
    .WIDTH (FW),
    .DEPTH (eha_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  always_comb begin
    fifo_out_ready     = !mem_wr_valid || mem_wr_ready;
    next_mem_wr_valid  = fifo_out_ready ? fifo_out_valid : mem_wr_valid;
    next_mem_wr        = fifo_out_ready ? eha_pkg::eha_mem_wr_t'(fifo_out) : mem_wr;
    next_mem_rd_en     = proc_rd_en;                                         // [RULE7]
    next_mem_rd_addr   = proc_rd_en ? proc_rd_addr : mem_rd_addr;
    next_proc_rd_valid = mem_rd_valid;
    next_proc_rd_data  = mem_rd_valid ? mem_rd_data : proc_rd_data;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state         <= eha_pkg::EHA_ST_INIT;
      active        <= 1'b0;
      idx           <= '0;
      tick_cnt      <= '0;
      live_cnt      <= '0;
      live_hold     <= '0;
      wr_ptr        <= '0;
      snap_start    <= '0;
      s1_valid      <= 1'b0;
      s1_bg         <= 1'b0;
      s1_idx        <= '0;
      s1_amp        <= '0;
      ev_ready      <= 1'b0;
      snap_base     <= '0;
      snap_done     <= 1'b0;
      snap_overrun  <= 1'b0;
      edac_err      <= 1'b0;
      bg_rd_data    <= '0;
      bg_rd_valid   <= 1'b0;
      mem_wr_valid  <= 1'b0;
      mem_wr        <= '0;
      mem_rd_en     <= 1'b0;
      mem_rd_addr   <= '0;
      proc_rd_valid <= 1'b0;
      proc_rd_data  <= '0;
    end else begin
      state         <= next_state;
      active        <= next_active;
      idx           <= next_idx;
      tick_cnt      <= next_tick_cnt;
      live_cnt      <= next_live_cnt;
      live_hold     <= next_live_hold;
      wr_ptr        <= next_wr_ptr;
      snap_start    <= next_snap_start;
      s1_valid      <= next_s1_valid;
      s1_bg         <= next_s1_bg;
      s1_idx        <= next_s1_idx;
      s1_amp        <= next_s1_amp;
      ev_ready      <= next_ev_ready;
      snap_base     <= next_snap_base;
      snap_done     <= next_snap_done;
      snap_overrun  <= next_snap_overrun;
      edac_err      <= next_edac_err;
      bg_rd_data    <= next_bg_rd_data;
      bg_rd_valid   <= next_bg_rd_valid;
      mem_wr_valid  <= next_mem_wr_valid;
      mem_wr        <= next_mem_wr;
      mem_rd_en     <= next_mem_rd_en;
      mem_rd_addr   <= next_mem_rd_addr;
      proc_rd_valid <= next_proc_rd_valid;
      proc_rd_data  <= next_proc_rd_data;
    end
  end

endmodule : eha_histogram_accumulator

// ===== hw/eha_pkg.sv
package eha_pkg;

  // ==========
  // Event word and histogram geometry
  localparam int AMP_W     = 12;
  localparam int DET_W     = 6;
  localparam int BIN_W     = 5;
  localparam int N_BINS    = 32;
  localparam int N_DETS    = 64;
  localparam int N_ACC     = N_BINS * N_DETS;
  localparam int ACC_IDX_W = BIN_W + DET_W;
  localparam int N_AMP     = 1 << AMP_W;

  // ==========
  // Circular storage memory
  localparam int MEM_BYTES  = 134217728;
  localparam int WORD_BYTES = 4;
  localparam int MEM_DW     = 32;
  localparam int MEM_AW     = 25;
  localparam int SNAP_WORDS = N_ACC + 1;
  localparam int FIFO_DEPTH = 16;

  // ==========
  // Timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SNAP_PERIOD_NS = 100000000;
  localparam int SNAP_CYCLES    = SNAP_PERIOD_NS / CLK_PERIOD_NS;

  // ==========
  // Carriers and states
  typedef struct packed {
    logic [AMP_W-1:0] amp;
    logic [DET_W-1:0] det;
  } eha_event_t;

  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [MEM_DW-1:0] data;
  } eha_mem_wr_t;

  typedef enum logic [1:0] {
    EHA_ST_INIT = 2'b00,
    EHA_ST_IDLE = 2'b01,
    EHA_ST_DUMP = 2'b10,
    EHA_ST_LIVE = 2'b11
  } eha_state_t;

endpackage : eha_pkg
